// File: rtl/flat_video_pkg.sv
// Shared constants, types and timing table for the flat-field video generator
package flat_video_pkg;

   // ==========================================================
   // Register map: map select and byte offsets
   localparam logic       MAP_IO            = 1'b0;
   localparam logic       MAP_COMPONENT     = 1'b1;
   localparam logic [7:0] IO_FORMAT_OFS     = 8'h00;  // video_format_code
   localparam logic [7:0] IO_CLASS_OFS      = 8'h01;  // primary input class
   localparam logic [7:0] IO_SOFT_RESET_OFS = 8'hFF;  // bit 7 restores defaults
   localparam logic [7:0] CMP_RX_SRC_OFS    = 8'hBA;
   localparam logic [7:0] CMP_CONTROL_OFS   = 8'hBF;  // free_run_control
   localparam logic [7:0] CMP_FILL_A_OFS    = 8'hC0;  // fill_colour_channel_a
   localparam logic [7:0] CMP_FILL_B_OFS    = 8'hC1;  // fill_colour_channel_b
   localparam logic [7:0] CMP_FILL_C_OFS    = 8'hC2;  // fill_colour_channel_c
   localparam logic [7:0] CMP_BUFFER_OFS    = 8'hC9;
   localparam logic [7:0] CMP_STATUS_OFS    = 8'hCA;

   // ==========================================================
   // Field positions and special values
   localparam int         FORCE_BIT         = 0;
   localparam int         AUTO_BIT          = 1;
   localparam int         MANUAL_BIT        = 2;
   localparam int         SOFT_RESET_BIT    = 7;
   localparam logic [7:0] RX_SRC_ENABLE     = 8'h01;
   localparam logic [7:0] BUFFER_BYPASS     = 8'h05;

   // ==========================================================
   // Reset values
   localparam logic [7:0] REG_RESET         = 8'h00;

   // ==========================================================
   // Class and format codes
   localparam logic [7:0] CLASS_SD_COMP     = 8'h01;
   localparam logic [7:0] CLASS_SD_GRAPH    = 8'h02;
   localparam logic [7:0] CLASS_RX_GRAPH    = 8'h04;
   localparam logic [7:0] CLASS_RX_COMP     = 8'h05;
   localparam logic [7:0] CODE_VGA          = 8'h08;
   localparam logic [7:0] CODE_1080I        = 8'h05;
   localparam logic [7:0] CODE_1080P        = 8'h1E;

   // ==========================================================
   // Built-in colours when manual colour is off (green, red, blue)
   localparam logic [7:0] AUTO_COL_G        = 8'h00;
   localparam logic [7:0] AUTO_COL_R        = 8'h00;
   localparam logic [7:0] AUTO_COL_B        = 8'hFF;
   localparam logic [7:0] PLAIN_COL_G       = 8'h00;
   localparam logic [7:0] PLAIN_COL_R       = 8'h00;
   localparam logic [7:0] PLAIN_COL_B       = 8'h00;

   localparam int         PIX_W             = 12;     // output bus per channel
   localparam logic [3:0] PIX_PAD           = 4'h0;   // low bits below the colour

   // ==========================================================
   // Formats and their raster timing (counts in pixel clocks / lines)
   typedef enum logic [1:0] {FMT_VGA60, FMT_480P, FMT_1080I60, FMT_1080P60} format_t;

   typedef struct packed {
      logic [11:0] h_total;
      logic [11:0] h_active;
      logic [11:0] h_fp;
      logic [11:0] h_sync;
      logic [10:0] v_total0;
      logic [10:0] v_total1;
      logic [10:0] v_active;
      logic [10:0] v_fp;
      logic [10:0] v_sync;
      logic        interlaced;
   } timing_t;

   localparam timing_t TIM_VGA60   = '{12'd800, 12'd640, 12'd16, 12'd96,
                                       11'd525, 11'd525, 11'd480, 11'd10, 11'd2, 1'b0};
   localparam timing_t TIM_480P    = '{12'd858, 12'd720, 12'd16, 12'd62,
                                       11'd525, 11'd525, 11'd480, 11'd9, 11'd6, 1'b0};
   localparam timing_t TIM_1080I60 = '{12'd2200, 12'd1920, 12'd88, 12'd44,
                                       11'd563, 11'd562, 11'd540, 11'd2, 11'd5, 1'b1};
   localparam timing_t TIM_1080P60 = '{12'd2200, 12'd1920, 12'd88, 12'd44,
                                       11'd1125, 11'd1125, 11'd1080, 11'd4, 11'd5, 1'b0};

   // Timing lookup for a format
   function automatic timing_t timing_of(input format_t f);
      case (f)
         FMT_480P:    timing_of = TIM_480P;
         FMT_1080I60: timing_of = TIM_1080I60;
         FMT_1080P60: timing_of = TIM_1080P60;
         default:     timing_of = TIM_VGA60;
      endcase
   endfunction : timing_of

endpackage : flat_video_pkg

// File: rtl/raster_counter.sv
// Horizontal and vertical raster counter producing sync and enable
`timescale 1ns/10ps
module raster_counter
   import flat_video_pkg::*;
(
   input  wire logic    i_core_clk,
   input  wire logic    i_reset_n,
   input  wire logic    i_run,
   input  wire timing_t i_timing,
   output logic         o_hsync,
   output logic         o_vsync,
   output logic         o_de,
   output logic         o_field,
   output logic         o_frame_start
);

   typedef struct packed {
      logic [11:0] h;
      logic [10:0] v;
      logic        field;
   } cnt_t;

   cnt_t s;
   cnt_t next_s;
   logic [10:0] lines;

   // ==========================================================
   // Counter advance, wraps with >= so a format change never overruns
   always_comb begin
      next_s = s;
      lines  = s.field ? i_timing.v_total1 : i_timing.v_total0;
      if (!i_run) begin
         next_s = '0;
      end else if (s.h >= i_timing.h_total - 12'd1) begin
         next_s.h = 12'd0;
         if (s.v >= lines - 11'd1) begin
            next_s.v     = 11'd0;
            next_s.field = i_timing.interlaced ? ~s.field : 1'b0;  // R4
         end else begin
            next_s.v = s.v + 11'd1;
         end
      end else begin
         next_s.h = s.h + 12'd1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Sync and enable decode from the counters
   assign o_de          = (s.h < i_timing.h_active) && (s.v < i_timing.v_active);  // R3
   assign o_hsync       = (s.h >= i_timing.h_active + i_timing.h_fp) &&
                          (s.h <  i_timing.h_active + i_timing.h_fp + i_timing.h_sync);  // R3
   assign o_vsync       = (s.v >= i_timing.v_active + i_timing.v_fp) &&
                          (s.v <  i_timing.v_active + i_timing.v_fp + i_timing.v_sync);  // R3
   assign o_field       = s.field;
   assign o_frame_start = i_run && (s.h == 12'd0) && (s.v == 11'd0) && !s.field;

   // ==========================================================
   // Checks
   property p_hcount_bound;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_run && $stable(i_timing) && (s.h < i_timing.h_total) |=> s.h < i_timing.h_total;
   endproperty
   a_hcount_bound: assert property (p_hcount_bound) else $error("pixel count overran line");  // R4

   property p_line_wrap;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_run && $stable(i_timing) && (s.h == i_timing.h_total - 12'd1) |=>
         s.h == 12'd0 && s.v != $past(s.v);
   endproperty
   a_line_wrap: assert property (p_line_wrap) else $error("line end did not wrap");  // R4

endmodule : raster_counter

// File: rtl/flat_video_generator.sv
// Free-run flat-field video generator with its register file and output mux
//
// What this block does
// [R1] Control bit 0 set replaces incoming video with internally generated output.
// [R2] Manual colour bit set takes each channel from its fill colour register.
// [R3] Free-run gives one flat colour, 8 bits MSB-aligned, plus matching syncs.
// [R4] Raster timing follows primary class and format code in IO map bytes.
// [R5] Receiver part: class 4, code 8 gives 640x480 at 60 Hz.
// [R6] Receiver part: class 5, code 5 gives 1080-line interlaced 60 fields.
// [R7] Non-receiver part: class 1, code 5 gives 1080-line interlaced 60 fields.
// [R8] Non-receiver part: class 2, code 8 gives 480-line progressive.
// [R9] Class 5 with code 1E gives 1080-line progressive at 60 Hz.
// [R10] Receiver parts need 01 written at BA before free-run drives output.
// [R11] Writing 05 at C9 stops frame buffering; programmed values apply directly.
// [R12] Fill registers at C0, C1, C2 drive green, red, blue.
// [R13] Software enables and formats the pixel bus outside this block.
// [R14] Manual bit clear gives a built-in colour chosen by the auto bit.
`timescale 1ns/10ps
module flat_video_generator
   import flat_video_pkg::*;
#(
   parameter bit HAS_RECEIVER = 1'b1
)(
   input  wire logic             i_core_clk,
   input  wire logic             i_reset_n,
   input  wire logic             i_reg_wr,
   input  wire logic             i_reg_rd,
   input  wire logic             i_reg_map,
   input  wire logic [7:0]       i_reg_addr,
   input  wire logic [7:0]       i_reg_wdata,
   output logic      [7:0]       o_reg_rdata,
   input  wire logic [PIX_W-1:0] i_video_green,
   input  wire logic [PIX_W-1:0] i_video_red,
   input  wire logic [PIX_W-1:0] i_video_blue,
   input  wire logic             i_video_hsync,
   input  wire logic             i_video_vsync,
   input  wire logic             i_video_de,
   output logic      [PIX_W-1:0] o_pix_green,
   output logic      [PIX_W-1:0] o_pix_red,
   output logic      [PIX_W-1:0] o_pix_blue,
   output logic                  o_hsync,
   output logic                  o_vsync,
   output logic                  o_de,
   output logic                  o_field,
   output logic                  o_freerun_active
);

   typedef struct packed {
      logic [7:0]       format_code;
      logic [7:0]       prim_class;
      logic [7:0]       rx_src;
      logic [7:0]       control;
      logic [7:0]       fill_a;
      logic [7:0]       fill_b;
      logic [7:0]       fill_c;
      logic [7:0]       buffer_ctl;
      format_t          act_fmt;
      logic [7:0]       act_a;
      logic [7:0]       act_b;
      logic [7:0]       act_c;
      logic             act_manual;
      logic             act_auto;
      logic [7:0]       rdata;
      logic [PIX_W-1:0] green;
      logic [PIX_W-1:0] red;
      logic [PIX_W-1:0] blue;
      logic             hs;
      logic             vs;
      logic             de;
      logic             fld;
      logic             active;
   } state_t;

   state_t  s;
   state_t  next_s;
   timing_t cur_timing;
   format_t req_fmt;
   logic    force_eff;
   logic    bypass;
   logic    gen_hs;
   logic    gen_vs;
   logic    gen_de;
   logic    gen_fld;
   logic    frame_start;
   logic    soft_rst;
   logic [7:0] col_g;
   logic [7:0] col_r;
   logic [7:0] col_b;

   // ==========================================================
   // Format decode from class and code, per part variant
   function automatic format_t decode_format(input logic [7:0] cls, input logic [7:0] code,
                                             input format_t keep);
      decode_format = keep;
      if (cls == CLASS_RX_COMP && code == CODE_1080P) begin
         decode_format = FMT_1080P60;                                        // R9
      end else if (HAS_RECEIVER) begin
         if (cls == CLASS_RX_GRAPH && code == CODE_VGA) begin
            decode_format = FMT_VGA60;                                       // R5
         end else if (cls == CLASS_RX_COMP && code == CODE_1080I) begin
            decode_format = FMT_1080I60;                                     // R6
         end
      end else begin
         if (cls == CLASS_SD_COMP && code == CODE_1080I) begin
            decode_format = FMT_1080I60;                                     // R7
         end else if (cls == CLASS_SD_GRAPH && code == CODE_VGA) begin
            decode_format = FMT_480P;                                        // R8
         end
      end
   endfunction : decode_format

   // ==========================================================
   // Free-run enable and timing source
   assign force_eff  = s.control[FORCE_BIT] &&
                       (!HAS_RECEIVER || s.rx_src == RX_SRC_ENABLE);         // R1 R10
   assign bypass     = (s.buffer_ctl == BUFFER_BYPASS);
   assign req_fmt    = decode_format(s.prim_class, s.format_code, s.act_fmt);  // R4
   assign cur_timing = timing_of(s.act_fmt);
   // Soft reset: IO map write with the restore bit set
   assign soft_rst   = i_reg_wr && i_reg_map == MAP_IO && i_reg_addr == IO_SOFT_RESET_OFS &&
                       i_reg_wdata[SOFT_RESET_BIT];

   raster_counter u_raster (
      .i_core_clk    (i_core_clk),
      .i_reset_n     (i_reset_n),
      .i_run         (s.active),
      .i_timing      (cur_timing),
      .o_hsync       (gen_hs),
      .o_vsync       (gen_vs),
      .o_de          (gen_de),
      .o_field       (gen_fld),
      .o_frame_start (frame_start)
   );

   // ==========================================================
   // Colour in force: manual fill or built-in choice
   always_comb begin
      if (s.act_manual) begin
         col_g = s.act_a;                                                    // R2 R12
         col_r = s.act_b;                                                    // R12
         col_b = s.act_c;                                                    // R12
      end else if (s.act_auto) begin
         col_g = AUTO_COL_G;                                                 // R14
         col_r = AUTO_COL_R;
         col_b = AUTO_COL_B;
      end else begin
         col_g = PLAIN_COL_G;                                                // R14
         col_r = PLAIN_COL_R;
         col_b = PLAIN_COL_B;
      end
   end

   // ==========================================================
   // Register writes, parameter buffering and pixel output stage
   always_comb begin
      next_s        = s;
      next_s.active = force_eff;
      // Register port writes
      if (i_reg_wr && i_reg_map == MAP_IO) begin
         case (i_reg_addr)
            IO_FORMAT_OFS: next_s.format_code = i_reg_wdata;
            IO_CLASS_OFS:  next_s.prim_class  = i_reg_wdata;
            default: ;
         endcase
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            CMP_RX_SRC_OFS:  next_s.rx_src     = i_reg_wdata;                // R10
            CMP_CONTROL_OFS: next_s.control    = i_reg_wdata;                // R1
            CMP_FILL_A_OFS:  next_s.fill_a     = i_reg_wdata;
            CMP_FILL_B_OFS:  next_s.fill_b     = i_reg_wdata;
            CMP_FILL_C_OFS:  next_s.fill_c     = i_reg_wdata;
            CMP_BUFFER_OFS:  next_s.buffer_ctl = i_reg_wdata;                // R11
            default: ;
         endcase
      end
      // Parameters reach the generator directly when bypassed or idle, else only at frame start
      if (bypass || !s.active || frame_start) begin                          // R11
         next_s.act_fmt    = req_fmt;
         next_s.act_a      = s.fill_a;
         next_s.act_b      = s.fill_b;
         next_s.act_c      = s.fill_c;
         next_s.act_manual = s.control[MANUAL_BIT];
         next_s.act_auto   = s.control[AUTO_BIT];
      end
      // Read data, one cycle after the strobe
      next_s.rdata = 8'h00;
      if (i_reg_rd && i_reg_map == MAP_IO) begin
         case (i_reg_addr)
            IO_FORMAT_OFS: next_s.rdata = s.format_code;
            IO_CLASS_OFS:  next_s.rdata = s.prim_class;
            default:       next_s.rdata = 8'h00;
         endcase
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            CMP_RX_SRC_OFS:  next_s.rdata = s.rx_src;
            CMP_CONTROL_OFS: next_s.rdata = s.control;
            CMP_FILL_A_OFS:  next_s.rdata = s.fill_a;
            CMP_FILL_B_OFS:  next_s.rdata = s.fill_b;
            CMP_FILL_C_OFS:  next_s.rdata = s.fill_c;
            CMP_BUFFER_OFS:  next_s.rdata = s.buffer_ctl;
            CMP_STATUS_OFS:  next_s.rdata = {4'h0, s.fld, s.act_fmt, s.active};
            default:         next_s.rdata = 8'h00;
         endcase
      end
      // Output mux: generated flat field or incoming video
      if (s.active) begin
         next_s.green = gen_de ? {col_g, PIX_PAD} : '0;                      // R3
         next_s.red   = gen_de ? {col_r, PIX_PAD} : '0;                      // R3
         next_s.blue  = gen_de ? {col_b, PIX_PAD} : '0;                      // R3
         next_s.hs    = gen_hs;
         next_s.vs    = gen_vs;
         next_s.de    = gen_de;
         next_s.fld   = gen_fld;
      end else begin
         next_s.green = i_video_green;
         next_s.red   = i_video_red;
         next_s.blue  = i_video_blue;
         next_s.hs    = i_video_hsync;
         next_s.vs    = i_video_vsync;
         next_s.de    = i_video_de;
         next_s.fld   = 1'b0;
      end
   end

   // State register with port reset and soft reset through the IO map
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || soft_rst) begin
         s         <= '0;
         s.act_fmt <= FMT_VGA60;
      end else begin
         s <= next_s;
      end
   end

   assign o_reg_rdata      = s.rdata;
   assign o_pix_green      = s.green;
   assign o_pix_red        = s.red;
   assign o_pix_blue       = s.blue;
   assign o_hsync          = s.hs;
   assign o_vsync          = s.vs;
   assign o_de             = s.de;
   assign o_field          = s.fld;
   assign o_freerun_active = s.active;

   // ==========================================================
   // Checks
   property p_force_takes_over;
      @(posedge i_core_clk) disable iff (!i_reset_n || soft_rst)
      force_eff ##1 force_eff |=> o_freerun_active && o_pix_green == ($past(gen_de, 1)
         ? {$past(col_g, 1), PIX_PAD} : '0);
   endproperty
   a_force_takes_over: assert property (p_force_takes_over) else $error("free-run not driving");  // R1

   property p_manual_colour;
      @(posedge i_core_clk) disable iff (!i_reset_n || soft_rst)
      s.active && s.act_manual && gen_de |=>
         o_pix_green == {$past(s.act_a), PIX_PAD} && o_pix_red == {$past(s.act_b), PIX_PAD} &&
         o_pix_blue == {$past(s.act_c), PIX_PAD};
   endproperty
   a_manual_colour: assert property (p_manual_colour) else $error("fill colour not on output");  // R2

   property p_msb_aligned;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_freerun_active && $past(s.active) |->
         o_pix_green[3:0] == PIX_PAD && o_pix_red[3:0] == PIX_PAD && o_pix_blue[3:0] == PIX_PAD;
   endproperty
   a_msb_aligned: assert property (p_msb_aligned) else $error("colour not MSB aligned");  // R3

   property p_vga_decode;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      HAS_RECEIVER && bypass && s.prim_class == CLASS_RX_GRAPH && s.format_code == CODE_VGA
         |=> s.act_fmt == FMT_VGA60;
   endproperty
   a_vga_decode: assert property (p_vga_decode) else $error("class 4 code 8 not VGA");  // R5

   property p_1080p_decode;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      bypass && s.prim_class == CLASS_RX_COMP && s.format_code == CODE_1080P
         |=> s.act_fmt == FMT_1080P60;
   endproperty
   a_1080p_decode: assert property (p_1080p_decode) else $error("code 1E not 1080p");  // R9

   property p_rx_gate;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      HAS_RECEIVER && s.rx_src != RX_SRC_ENABLE |=> !o_freerun_active;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("free-run without source enable");  // R10

   property p_buffered_hold;
      @(posedge i_core_clk) disable iff (!i_reset_n || soft_rst)
      s.active && !bypass && !frame_start |=> s.act_fmt == $past(s.act_fmt) &&
         s.act_a == $past(s.act_a);
   endproperty
   a_buffered_hold: assert property (p_buffered_hold) else $error("buffered value changed early");  // R11

   property p_auto_colour;
      @(posedge i_core_clk) disable iff (!i_reset_n || soft_rst)
      s.active && !s.act_manual && s.act_auto && gen_de |=>
         o_pix_blue == {AUTO_COL_B, PIX_PAD} && o_pix_green == {AUTO_COL_G, PIX_PAD};
   endproperty
   a_auto_colour: assert property (p_auto_colour) else $error("built-in colour wrong");  // R14

endmodule : flat_video_generator

// File: testbench/pixel_sink.sv
// Downstream pixel receiver model measuring active and sync run lengths
`timescale 1ns/10ps
module pixel_sink (
   input  wire logic        i_core_clk,
   input  wire logic        i_de,
   input  wire logic        i_hsync,
   output logic      [11:0] o_de_run,
   output logic      [11:0] o_hsync_run
);
   logic [11:0] de_cnt;
   logic [11:0] hs_cnt;
   // Count high runs, latch each length when the level drops
   always_ff @(posedge i_core_clk) begin
      de_cnt <= i_de ? de_cnt + 12'h001 : 12'h000;
      hs_cnt <= i_hsync ? hs_cnt + 12'h001 : 12'h000;
      if (!i_de && de_cnt != 12'h000) o_de_run <= de_cnt;
      if (!i_hsync && hs_cnt != 12'h000) o_hsync_run <= hs_cnt;
   end
endmodule : pixel_sink

// File: testbench/tb.sv
// Self-checking bench for the flat-field video generator
`timescale 1ns/10ps
module tb;
   import flat_video_pkg::*;
   // ==========================================================
   // Signals
   logic             i_core_clk, i_reset_n, i_reg_wr, i_reg_rd, i_reg_map;
   logic [7:0]       i_reg_addr, i_reg_wdata, o_reg_rdata, rdv;
   logic [PIX_W-1:0] i_video_green, i_video_red, i_video_blue;
   logic [PIX_W-1:0] o_pix_green, o_pix_red, o_pix_blue;
   logic             i_video_hsync, i_video_vsync, i_video_de;
   logic             o_hsync, o_vsync, o_de, o_field, o_freerun_active;
   logic [11:0]      de_run, hs_run;
   int               n_errors, n_checks;
   logic [7:0]       fill [3] = '{8'h11, 8'h22, 8'h33};
   logic [7:0]       cls [6]  = '{CLASS_RX_GRAPH, CLASS_RX_COMP, CLASS_RX_COMP, 8'h07,
                                  CLASS_SD_COMP, CLASS_SD_GRAPH};
   logic [7:0]       code [6] = '{CODE_VGA, CODE_1080I, CODE_1080P, 8'h1E, CODE_1080I, CODE_VGA};
   logic [1:0]       fmt [6]  = '{2'd0, 2'd2, 2'd3, 2'd3, 2'd3, 2'd3};
   logic [1:0]       fmt_norx [6] = '{2'd0, 2'd0, 2'd3, 2'd3, 2'd2, 2'd1};
   logic [7:0]       rdata_norx, rdv_norx;
   logic             active_norx;

   flat_video_generator uut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_map(i_reg_map),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_video_green(i_video_green), .i_video_red(i_video_red),
      .i_video_blue(i_video_blue), .i_video_hsync(i_video_hsync),
      .i_video_vsync(i_video_vsync), .i_video_de(i_video_de),
      .o_pix_green(o_pix_green), .o_pix_red(o_pix_red), .o_pix_blue(o_pix_blue),
      .o_hsync(o_hsync), .o_vsync(o_vsync), .o_de(o_de), .o_field(o_field),
      .o_freerun_active(o_freerun_active));
   pixel_sink sink (.i_core_clk(i_core_clk), .i_de(o_de), .i_hsync(o_hsync),
      .o_de_run(de_run), .o_hsync_run(hs_run));
   // Variant without receiver: own decode table, no source gate
   flat_video_generator #(.HAS_RECEIVER(1'b0)) uut_norx (.i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_map(i_reg_map),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata_norx),
      .i_video_green(i_video_green), .i_video_red(i_video_red),
      .i_video_blue(i_video_blue), .i_video_hsync(i_video_hsync),
      .i_video_vsync(i_video_vsync), .i_video_de(i_video_de), .o_pix_green(), .o_pix_red(),
      .o_pix_blue(), .o_hsync(), .o_vsync(), .o_de(), .o_field(),
      .o_freerun_active(active_norx));

   // ==========================================================
   // Register port and checking tasks
   task automatic wr(input logic m, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      i_reg_wr = 1'b1; i_reg_map = m; i_reg_addr = a; i_reg_wdata = d;
      @(negedge i_core_clk);
      i_reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic m, input logic [7:0] a);
      @(negedge i_core_clk);
      i_reg_rd = 1'b1; i_reg_map = m; i_reg_addr = a;
      @(negedge i_core_clk);
      i_reg_rd = 1'b0;
      rdv = o_reg_rdata;
      rdv_norx = rdata_norx;
   endtask : rd
   task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Bounded wait for de (0) or hsync (1) to reach a level
   task automatic wait_sig(input int which, input logic lvl);
      for (int k = 0; k < 5000; k++) begin
         if ((which == 0 ? o_de : o_hsync) === lvl) return;
         @(negedge i_core_clk);
      end
      n_errors++;
      $display("BAD wait expected %0d seen timeout", lvl);
   endtask : wait_sig
   // Watch one line: colour in de, zero outside, then run lengths
   task automatic line(input logic [11:0] act, input logic [11:0] hs);
      wait_sig(0, 1'b1);
      check("green", o_pix_green, {fill[0], PIX_PAD});
      check("red", o_pix_red, {fill[1], PIX_PAD});
      check("blue", o_pix_blue, {fill[2], PIX_PAD});
      check("vsync", o_vsync, 1'b0);
      check("field", o_field, 1'b0);
      wait_sig(0, 1'b0);
      check("blank", o_pix_blue, 12'h000);
      wait_sig(1, 1'b1);
      wait_sig(1, 1'b0);
      @(negedge i_core_clk);
      check("de_run", de_run, act);
      check("hsync_run", hs_run, hs);
   endtask : line
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   // ==========================================================
   // Clock and watchdog
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   initial begin
      #(20 * 50000);
      n_errors++;
      summarize();
   end

   // ==========================================================
   // Test sequence
   initial begin
      n_errors = 0; n_checks = 0; i_reset_n = 1'b0; i_reg_wr = 1'b0; i_reg_rd = 1'b0;
      i_reg_map = 1'b0; i_reg_addr = 8'h00; i_reg_wdata = 8'h00;
      i_video_green = 12'hA5A; i_video_red = 12'h3C3; i_video_blue = 12'h0F0;
      i_video_hsync = 1'b1; i_video_vsync = 1'b0; i_video_de = 1'b0;
      repeat (6) @(negedge i_core_clk);
      i_reset_n = 1'b1;
      rd(1'b1, CMP_CONTROL_OFS);
      check("control", rdv, REG_RESET);
      for (int k = 0; k < 3; k++) wr(1'b1, CMP_FILL_A_OFS + 8'(k), fill[k]);
      for (int k = 0; k < 3; k++) begin
         rd(1'b1, CMP_FILL_A_OFS + 8'(k));
         check("fill", rdv, fill[k]);
      end
      rd(1'b1, 8'hC5);
      check("unmapped", rdv, 8'h00);
      check("pass", o_pix_green, i_video_green);
      // Class and code pairs select the raster; unknown pair keeps it
      for (int k = 0; k < 6; k++) begin
         wr(1'b0, IO_CLASS_OFS, cls[k]);
         wr(1'b0, IO_FORMAT_OFS, code[k]);
         rd(1'b1, CMP_STATUS_OFS);
         check("format", rdv[2:1], fmt[k]);
         check("format_norx", rdv_norx[2:1], fmt_norx[k]);
      end
      // Force without source enable stays gated
      wr(1'b1, CMP_BUFFER_OFS, BUFFER_BYPASS);
      wr(1'b1, CMP_CONTROL_OFS, 8'h05);
      repeat (3) @(negedge i_core_clk);
      check("gated", o_freerun_active, 1'b0);
      check("norx_active", active_norx, 1'b1);
      wr(1'b1, CMP_RX_SRC_OFS, RX_SRC_ENABLE);
      repeat (2) @(negedge i_core_clk);
      check("active", o_freerun_active, 1'b1);
      line(12'd1920, 12'd44);
      // Built-in colours with the manual bit clear
      wr(1'b1, CMP_CONTROL_OFS, 8'h03);
      wait_sig(0, 1'b1);
      check("auto", o_pix_blue, {AUTO_COL_B, PIX_PAD});
      wr(1'b1, CMP_CONTROL_OFS, 8'h01);
      // Let the current line end so the new colour is on show
      wait_sig(0, 1'b0);
      wait_sig(0, 1'b1);
      check("plain", o_pix_blue, {PLAIN_COL_B, PIX_PAD});
      // Back to normal video, then VGA raster
      wr(1'b1, CMP_CONTROL_OFS, 8'h00);
      repeat (3) @(negedge i_core_clk);
      check("released", o_pix_red, i_video_red);
      wr(1'b0, IO_CLASS_OFS, CLASS_RX_GRAPH);
      wr(1'b0, IO_FORMAT_OFS, CODE_VGA);
      wr(1'b1, CMP_CONTROL_OFS, 8'h05);
      line(12'd640, 12'd96);
      // Soft reset restores defaults
      wr(1'b0, IO_SOFT_RESET_OFS, 8'h80);
      rd(1'b1, CMP_CONTROL_OFS);
      check("soft", rdv, REG_RESET);
      check("idle", o_freerun_active, 1'b0);
      summarize();
   end
endmodule : tb
